// >>> ssm_ctl.sv
/*
  controller end: takes one user request at a time, drives the ram
  command port, inserts dummy reads before writes that follow reads,
  and sequences sleep entry and exit.
  assumes user holds a request until ack.
*/
`timescale 1ns/10ps
module ssm_ctl
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ssm_if.ctl lnk,
  input wire logic user_sleep,
  input wire logic user_req,
  input wire logic user_we,
  input wire logic [ADDR_W-1:0] user_addr,
  input wire logic [DATA_W-1:0] user_wdata,
  output logic user_ack,
  output logic [DATA_W-1:0] user_rdata,
  output logic user_ready
);
  ssm_cmd_t cmd_ff, nxt_cmd;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] wd_ff, nxt_wd;
  logic oe_ff, nxt_oe;
  logic zz_ff, nxt_zz;
  logic [3:0] rec_ff, nxt_rec;
  logic last_rd_ff, nxt_last_rd;
  logic [1:0] rd_pipe_ff, nxt_rd_pipe;
  logic ack_ff, nxt_ack;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic busy;

  assign busy = (cmd_ff != SSM_CMD_DESELECT) || (rd_pipe_ff != 2'h0);

  // ==========================================================
  // command and sleep sequencing
  always_comb begin
    nxt_cmd = SSM_CMD_DESELECT;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_oe = 1'b0;
    nxt_zz = zz_ff;
    nxt_rec = rec_ff;
    nxt_last_rd = last_rd_ff;
    nxt_rd_pipe = {rd_pipe_ff[0], 1'b0};
    nxt_ack = 1'b0;
    nxt_rdata = rdata_ff;
    if (rd_pipe_ff[1]) begin
      nxt_rdata = lnk.dq_in;
    end
    if (zz_ff) begin
      if (!user_sleep) begin
        nxt_zz = 1'b0;
        nxt_rec = REC_LOAD;
      end
    end else if (user_sleep && !busy && !user_req && rec_ff == 4'h0) begin
      nxt_zz = 1'b1;
    end else begin
      if (rec_ff != 4'h0) begin
        nxt_rec = rec_ff - 4'h1;
      end
      if (user_req && !ack_ff && !busy && !user_sleep) begin
        if (rec_ff != 4'h0) begin
          // ram ignores every command until recovered, so hold all requests
          nxt_cmd = SSM_CMD_DESELECT;
        end else if (user_we && last_rd_ff) begin
          nxt_cmd = SSM_CMD_DUMMY_READ;
          nxt_addr = user_addr;
          nxt_last_rd = 1'b0;
        end else if (user_we) begin
          nxt_cmd = SSM_CMD_WRITE;
          nxt_addr = user_addr;
          nxt_wd = user_wdata;
          nxt_oe = 1'b1;
          nxt_ack = 1'b1;
        end else begin
          nxt_cmd = SSM_CMD_READ;
          nxt_addr = user_addr;
          nxt_last_rd = 1'b1;
          nxt_rd_pipe = {rd_pipe_ff[0], 1'b1};
        end
      end
    end
    if (rd_pipe_ff[1]) begin
      nxt_ack = 1'b1;
    end
  end

  // register controller state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= SSM_CMD_DESELECT;
      addr_ff <= 4'h0;
      wd_ff <= 8'h00;
      oe_ff <= 1'b0;
      zz_ff <= 1'b0;
      rec_ff <= 4'h0;
      last_rd_ff <= 1'b0;
      rd_pipe_ff <= 2'h0;
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      user_ready <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      wd_ff <= nxt_wd;
      oe_ff <= nxt_oe;
      zz_ff <= nxt_zz;
      rec_ff <= nxt_rec;
      last_rd_ff <= nxt_last_rd;
      rd_pipe_ff <= nxt_rd_pipe;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      user_ready <= !nxt_zz && (nxt_rec == 4'h0);
    end
  end

  assign user_ack = ack_ff;
  assign user_rdata = rdata_ff;
  assign lnk.sleep_request = zz_ff;
  assign lnk.cmd = cmd_ff;
  assign lnk.addr = addr_ff;
  assign lnk.dq_ctl_out = wd_ff;
  assign lnk.dq_ctl_oe = oe_ff;
endmodule

// >>> ssm_pkg.sv
/*
  package for the sleep mode control block of a synchronous burst ram:
  command codes, states, widths and timing counts shared by both ends.
  assumes a single 25 MHz clock shared by controller and ram.
*/
package ssm_pkg;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH = 16;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SLEEP_ENTRY_CYCLES = 2;
  localparam int unsigned SLEEP_RECOVERY_NS = 20;
  localparam int unsigned SLEEP_RECOVERY_CYCLES =
    (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] ENTRY_LAST = 2'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic [3:0] REC_LOAD = 4'(SLEEP_RECOVERY_CYCLES);
  // ==========================================================
  // command port codes
  typedef enum logic [1:0] {
    SSM_CMD_DESELECT = 2'h0,
    SSM_CMD_READ = 2'h1,
    SSM_CMD_WRITE = 2'h2,
    SSM_CMD_DUMMY_READ = 2'h3
  } ssm_cmd_t;
  // ==========================================================
  // device power states, one-hot
  typedef enum logic [3:0] {
    SSM_ST_RUN = 4'h1,
    SSM_ST_ENTER = 4'h2,
    SSM_ST_SLEEP = 4'h4,
    SSM_ST_RECOVER = 4'h8
  } ssm_state_t;
endpackage

// >>> ssm_if.sv
/*
  pin-level link between the memory controller and the ram.
  resolves the shared data bus here from the enables, ram drive first.
*/
`timescale 1ns/10ps
interface ssm_if;
  import ssm_pkg::*;
  logic sleep_request;
  ssm_cmd_t cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_ctl_out;
  logic dq_ctl_oe;
  logic [DATA_W-1:0] dq_ram_out;
  logic dq_ram_oe;
  logic [DATA_W-1:0] dq_in;
  // ==========================================================
  // bus resolution, zero where nobody drives (pull-down model)
  assign dq_in = dq_ram_oe ? dq_ram_out : (dq_ctl_oe ? dq_ctl_out : '0);
  modport ram (input sleep_request, cmd, addr, dq_in, output dq_ram_out, dq_ram_oe);
  modport ctl (output sleep_request, cmd, addr, dq_ctl_out, dq_ctl_oe, input dq_in);
endinterface

// >>> ssm_ram.sv
/*
  ram end: storage, command decode, single-cycle-deselect output drive
  and the sleep entry, hold and recovery sequence.
  assumes sleep_request is met to the clock's setup and hold window.
*/
// What this block does
// - sleep request reads low when not driven
// - enter sleep two cycles after request rises
// - contents and state kept during sleep
// - resume only after recovery time elapses
// - sleeping device is deselected, no accesses
// - ignore inputs, data outputs tri-stated
// - stay asleep while request stays high
// - request sampled on clock, asynchronous level
// - controller finishes accesses before requesting sleep
// - ignore every command, reads too, during recovery
// - dummy reads at turnarounds avoid contention
`timescale 1ns/10ps
module ssm_ram
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ssm_if.ram lnk,
  output logic asleep
);
  ssm_state_t state_ff, nxt_state;
  logic [1:0] ent_cnt_ff, nxt_ent_cnt;
  logic [3:0] rec_cnt_ff, nxt_rec_cnt;
  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic req;
  logic active;

  // ==========================================================
  // power sequence
  // undriven request resolves low (pull-down)
  assign req = (lnk.sleep_request === 1'b1);
  assign active = (state_ff == SSM_ST_RUN) || (state_ff == SSM_ST_ENTER);

  // next power state
  always_comb begin
    nxt_state = state_ff;
    nxt_ent_cnt = ent_cnt_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (state_ff)
      SSM_ST_RUN: begin
        nxt_ent_cnt = 2'h0;
        if (req) begin
          nxt_state = SSM_ST_ENTER;
        end
      end
      SSM_ST_ENTER: begin
        nxt_ent_cnt = ent_cnt_ff + 2'h1;
        if (!req) begin
          nxt_state = SSM_ST_RUN;
        end else if (ent_cnt_ff == ENTRY_LAST - 2'h1) begin
          nxt_state = SSM_ST_SLEEP;
        end
      end
      SSM_ST_SLEEP: begin
        nxt_rec_cnt = REC_LOAD;
        if (!req) begin
          nxt_state = SSM_ST_RECOVER;
        end
      end
      SSM_ST_RECOVER: begin
        if (req) begin
          nxt_state = SSM_ST_SLEEP;
        end else if (rec_cnt_ff <= 4'h1) begin
          nxt_state = SSM_ST_RUN;
        end else begin
          nxt_rec_cnt = rec_cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = SSM_ST_RUN;
      end
    endcase
  end

  // register power state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SSM_ST_RUN;
      ent_cnt_ff <= 2'h0;
      rec_cnt_ff <= 4'h0;
      asleep <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ent_cnt_ff <= nxt_ent_cnt;
      rec_cnt_ff <= nxt_rec_cnt;
      asleep <= (nxt_state == SSM_ST_SLEEP);
    end
  end

  // ==========================================================
  // datapath
  // read data and single-cycle-deselect output enable
  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe = 1'b0;
    if (active && (lnk.cmd == SSM_CMD_READ)) begin
      nxt_dout = mem_ff[lnk.addr];
      nxt_oe = 1'b1;
    end else if (active && (lnk.cmd == SSM_CMD_DUMMY_READ)) begin
      nxt_dout = mem_ff[lnk.addr];
    end
    if (state_ff == SSM_ST_SLEEP || state_ff == SSM_ST_RECOVER) begin
      nxt_oe = 1'b0;
    end
  end

  // writes only while awake; sleep leaves storage untouched
  always_ff @(posedge ref_clk) begin
    if (active && (lnk.cmd == SSM_CMD_WRITE)) begin
      mem_ff[lnk.addr] <= lnk.dq_in;
    end
  end

  // register output drivers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  assign lnk.dq_ram_out = dout_ff;
  assign lnk.dq_ram_oe = oe_ff;
endmodule

// >>> ssm_checker.sv
/*
  ssm_checker: assertions on the ram link and the ram sleep flag.
  assumes one clock domain, instantiated beside the link.
*/
`timescale 1ns/10ps
module ssm_checker
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sleep_request,
  input wire ssm_cmd_t cmd,
  input wire logic dq_ctl_oe,
  input wire logic dq_ram_oe,
  input wire logic asleep
);
  // ==========================================================
  // link properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  entry_not_early_a: assert property ($rose(sleep_request) |=> !asleep)
    else $error("sleep entered early");
  entry_on_time_a: assert property ($rose(sleep_request) ##1 sleep_request |=> asleep)
    else $error("sleep entry late");
  sleep_hold_a: assert property (asleep && sleep_request |=> asleep)
    else $error("left sleep while requested");
  wake_exit_a: assert property (asleep && !sleep_request |=> !asleep)
    else $error("sleep not left");
  rec_no_write_a: assert property ($fell(asleep) |-> cmd != SSM_CMD_WRITE)
    else $error("write during recovery");
  sleep_hiz_a: assert property (asleep |-> !dq_ram_oe && !dq_ctl_oe)
    else $error("bus driven in sleep");
  read_drive_a: assert property (cmd == SSM_CMD_READ && !asleep && !sleep_request
    |=> dq_ram_oe ##1 !dq_ram_oe)
    else $error("read drive wrong");
  dummy_hiz_a: assert property (cmd == SSM_CMD_DUMMY_READ |=> !dq_ram_oe)
    else $error("dummy read drove bus");
  no_fight_a: assert property (!(dq_ram_oe && dq_ctl_oe))
    else $error("bus contention");
  idle_sleep_a: assert property ($rose(sleep_request) |-> cmd == SSM_CMD_DESELECT)
    else $error("sleep with access pending");
endmodule

// >>> sram_sleep_mode_control_tb.sv
/*
  sram_sleep_mode_control_tb: controller and ram joined by the link,
  driven from the user side. assumes the package timing constants.
*/
`timescale 1ns/10ps
module sram_sleep_mode_control_tb
  import ssm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic user_sleep = 1'b0;
  logic user_req = 1'b0;
  logic user_we = 1'b0;
  logic [ADDR_W-1:0] user_addr = '0;
  logic [DATA_W-1:0] user_wdata = '0;
  logic user_ack;
  logic [DATA_W-1:0] user_rdata;
  logic user_ready;
  logic asleep;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
  // ==========================================================
  // structure
  ssm_if lnk();
  ssm_ram ssm_ram_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk), .asleep(asleep));
  ssm_ctl ssm_ctl_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk),
    .user_sleep(user_sleep), .user_req(user_req), .user_we(user_we),
    .user_addr(user_addr), .user_wdata(user_wdata), .user_ack(user_ack),
    .user_rdata(user_rdata), .user_ready(user_ready));
  ssm_checker ssm_checker_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .sleep_request(lnk.sleep_request), .cmd(lnk.cmd), .dq_ctl_oe(lnk.dq_ctl_oe),
    .dq_ram_oe(lnk.dq_ram_oe), .asleep(asleep));
  // clock and hang guard
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  // ==========================================================
  // tasks
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    user_req <= 1'b1;
    user_we <= we;
    user_addr <= a;
    user_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (user_ack !== 1'b1 && n < 20);
    `CHK(user_ack, 1'b1)
    user_req <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(user_rdata, e)
  endtask
  task automatic nap(input int len);
    int n;
    user_sleep <= 1'b1;
    repeat (len) @(posedge ref_clk);
    #1;
    `CHK(user_ready, 1'b0)
    `CHK(asleep, (len > SLEEP_ENTRY_CYCLES))
    @(posedge ref_clk);
    user_sleep <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (user_ready !== 1'b1 && n < 20);
    `CHK(asleep, 1'b0)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    `CHK(lnk.dq_in, 8'h00)
    for (int i = 0; i < 4; i++) xfer(1'b1, 4'(i), 8'(8'ha5 ^ i));
    rd(4'h0, 8'ha5);
    xfer(1'b1, 4'hf, 8'h3c);
    rd(4'hf, 8'h3c);
    $display("test access done");
    nap(12);
    xfer(1'b1, 4'h7, 8'h5a);
    for (int i = 0; i < 4; i++) rd(4'(i), 8'(8'ha5 ^ i));
    rd(4'h7, 8'h5a);
    $display("test sleep done");
    nap(1);
    rd(4'hf, 8'h3c);
    $display("test short request done");
    results();
  end
endmodule
